/* File: inc/brs_pkg.sv */
package brs_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned POWER_UP_TIMER_TIME_MS = 64;
  // 64 ms at 200 MHz, longest time rounds down
  localparam int unsigned POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_TIME_MS * (CLK_HZ / 1000);
  // brownout_filter_time has no printed figure: plain default
  localparam int unsigned FILTER_TIME_NS = 1000;
  // least time rounds up
  localparam int unsigned FILTER_CYCLES = (FILTER_TIME_NS * CLK_MHZ + 999) / 1000;
  // oscillator cycles after the reset pin goes high
  localparam int unsigned EXT_RELEASE_CYCLES = 10;

  // register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] BRN_CTRL_OFS = 8'h00;
  localparam logic [7:0] BRN_STAT_OFS = 8'h04;

  // brownout_control fields
  localparam int unsigned SOFT_EN_BIT = 7;
  localparam int unsigned BANDGAP_BIT = 6;
  localparam int unsigned READY_BIT = 0;
  localparam logic SOFT_EN_RST = 1'b1;
  localparam logic BANDGAP_RST = 1'b0;

  // status fields
  localparam int unsigned STAT_GENERIC_BIT = 0;
  localparam int unsigned STAT_POWER_UP_TIMER_BIT = 1;
  localparam int unsigned STAT_EXT_EN_BIT = 2;
  localparam int unsigned STAT_HOLD_BIT = 3;
  localparam int unsigned STAT_MODE_LSB = 4;

  // brownout_mode_select encodings
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_SOFT = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h0;

  // static configuration word bits
  typedef struct packed {
    logic [1:0] brownout_mode_select;
    logic power_up_timer_enable_n;
    logic brownout_level_select;
    logic low_power_brownout_n;
    logic ext_reset_pin_enable;
    logic low_voltage_prog_enable;
  } brs_cfg_t;

  // inputs from supply detectors, reset pin and oscillator
  typedef struct packed {
    logic por_active;
    logic below_threshold;
    logic circuit_ready;
    logic lp_trip;
    logic external_reset_pin_n;
    logic osc_ready;
  } brs_ana_in_t;

  // controls to the analog detectors
  typedef struct packed {
    logic brownout_enable;
    logic brownout_level_select;
    logic bandgap_force_on;
    logic low_power_brownout_enable;
  } brs_ana_out_t;

endpackage

/* File: hdl/brs_top.sv */
// Functional notes
// - core stays in reset while the power-on detector is active
// - power-up timer gives a 64 ms delay after power-on or brown-out
// - core held while timer counts; timer enabled when its enable_n bit is 0
// - timer starts only after power-on and brown-out both release
// - brown-out holds reset at low supply; one bit selects the trip level
// - only dips lasting at least the filter time cause a brown-out reset; a low-power detector trip here holds the core unfiltered
// - mode 11: always protected, start waits ready, wake not delayed
// - mode 10: protected only awake; start and wake wait for ready
// - mode 01: software bit enables; start-up never waits for brown-out
// - software mode protects once ready, shows ready, ignores sleep
// - mode 00 or 01 with bit cleared: brown-out off, start at once
// - in forced-on modes ready is set before the core runs
// - bit 7 always read/write, acts only in mode 01
// - bit 6 forces bandgap on in modes 10 and 01, else no effect
// - read-only bit 0 shows whether the brown-out circuit is active
// - low-power detector trip holds core and sets brown-out cause
// - low-power request ORed with main brown-out gives generic flag
// - low-power detector enabled by config bit, erased means disabled
// - reset pin enabled when prog bit is 1 or pin-enable bit is 1
// - enabled reset pin held low keeps the device in reset
// - core starts 10 clocks after the reset pin goes high; here 13: 2 in the synchroniser, 10 counted, 1 in the hold register
//
// Implementation choices: the AHB-Lite register port and the register offsets.
module brs_top #(
  parameter int unsigned POWER_UP_TIMER_CYCLES = brs_pkg::POWER_UP_TIMER_CYCLES,
  parameter int unsigned FILTER_CYCLES = brs_pkg::FILTER_CYCLES,
  parameter int unsigned EXT_RELEASE_CYCLES = brs_pkg::EXT_RELEASE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire brs_pkg::brs_cfg_t cfg,
  input wire brs_pkg::brs_ana_in_t ana_in,
  input wire logic sleep_mode,
  output brs_pkg::brs_ana_out_t ana_out,
  output logic generic_brownout,
  output logic core_reset_hold
);

  localparam int unsigned POWER_UP_TIMER_W = $clog2(POWER_UP_TIMER_CYCLES + 1);
  localparam int unsigned FLT_W = $clog2(FILTER_CYCLES + 1);
  localparam int unsigned EXT_W = $clog2(EXT_RELEASE_CYCLES + 1);

  // refuse counts the counters cannot serve
  if (POWER_UP_TIMER_CYCLES < 1 || FILTER_CYCLES < 1 || EXT_RELEASE_CYCLES < 1)
  begin : g_bad_param
    $error("brs_top: every cycle count must be at least one");
  end

  brs_pkg::brs_ana_in_t sync1_r;
  brs_pkg::brs_ana_in_t ana_s;
  logic ext_en;
  logic arst_n;
  logic rel1_r;
  logic rel2_r;
  logic hold_r;
  logic bor_enable;
  logic protect;
  logic ready_s;
  logic ready_wait;
  logic [FLT_W-1:0] flt_cnt_r;
  logic bor_trip_r;
  logic lp_req;
  logic power_up_timer_arm_r;
  logic [POWER_UP_TIMER_W-1:0] power_up_timer_cnt_r;
  logic power_up_timer_busy;
  logic power_up_timer_en;
  logic ext_active_s;
  logic [EXT_W-1:0] ext_cnt_r;
  logic soft_en_r;
  logic bandgap_r;
  logic wr_pend_r;
  logic [brs_pkg::ADDR_W-1:0] wr_addr_r;
  logic addr_sel;
  logic [31:0] rd_nxt;
  logic [1:0] mode;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  assign mode = cfg.brownout_mode_select;

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers

  // two flops for every detector and pin level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // a released pin reads high, so no false press follows reset
      sync1_r <= '{external_reset_pin_n: 1'b1, default: 1'b0};
      ana_s <= '{external_reset_pin_n: 1'b1, default: 1'b0};
    end
    else
    begin
      sync1_r <= ana_in;
      ana_s <= sync1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // brown-out mode decode

  // which modes run the brown-out circuit
  always_comb
  begin
    unique case (mode)
      brs_pkg::MODE_ALWAYS: bor_enable = 1'b1;
      brs_pkg::MODE_AWAKE: bor_enable = !sleep_mode;
      brs_pkg::MODE_SOFT: bor_enable = soft_en_r;
      brs_pkg::MODE_OFF: bor_enable = 1'b0;
    endcase
  end

  // protection only counts once the circuit reports ready
  assign ready_s = ana_s.circuit_ready & bor_enable;
  assign protect = ready_s;
  // forced-on modes hold the core until ready; software mode never waits
  assign ready_wait = mode[1] & bor_enable & !ana_s.circuit_ready;

  a_mode_off_idle: assert property ((mode == brs_pkg::MODE_OFF) |->
    !ana_out.brownout_enable && !ana_out.bandgap_force_on)
    else $error("brown-out active in off mode");
  a_soft_enable: assert property ((mode == brs_pkg::MODE_SOFT) |->
    (ana_out.brownout_enable == soft_en_r)) else $error("soft enable not followed");
  a_ready_wait: assert property ((mode[1] && bor_enable && !ana_s.circuit_ready) |=>
    core_reset_hold) else $error("core ran before brown-out ready");

  // analog controls
  always_comb
  begin
    ana_out.brownout_enable = bor_enable;
    ana_out.brownout_level_select = cfg.brownout_level_select;
    ana_out.bandgap_force_on = bandgap_r & (mode[1] ^ mode[0]);
    ana_out.low_power_brownout_enable = !cfg.low_power_brownout_n;
  end

  a_bandgap_mode: assert property ((mode[1] == mode[0]) |-> !ana_out.bandgap_force_on)
    else $error("bandgap forced in mode 11 or 00");

  //////////////////////////////////////////////////////////////////////////
  // brown-out noise filter

  // supply must stay low a full filter time before the trip
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flt_cnt_r <= '0;
    else if (!protect || !ana_s.below_threshold)
      flt_cnt_r <= '0;
    else if (flt_cnt_r != FLT_W'(FILTER_CYCLES - 1))
      flt_cnt_r <= flt_cnt_r + FLT_W'(1);
  end

  // trip holds until the supply is back above threshold or protection drops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bor_trip_r <= 1'b0;
    else
      bor_trip_r <= protect & ana_s.below_threshold
        & (bor_trip_r | (flt_cnt_r == FLT_W'(FILTER_CYCLES - 1)));
  end

  a_filter_len: assert property ($rose(bor_trip_r) |->
    ($past(flt_cnt_r) == FLT_W'(FILTER_CYCLES - 1))) else $error("brown-out trip too early");

  // low-power detector joins the main brown-out
  assign lp_req = !cfg.low_power_brownout_n & ana_s.lp_trip;
  assign generic_brownout = bor_trip_r | lp_req;

  a_lp_hold: assert property (lp_req |=> core_reset_hold)
    else $error("low-power trip did not hold core");

  //////////////////////////////////////////////////////////////////////////
  // power-up timer

  assign power_up_timer_en = !cfg.power_up_timer_enable_n;

  // armed by power-on or brown-out, runs once both have released
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      power_up_timer_arm_r <= 1'b1;
    else if (ana_s.por_active || generic_brownout)
      power_up_timer_arm_r <= 1'b1;
    else
      power_up_timer_arm_r <= 1'b0;
  end

  // down counter, the arming cycle counts as the first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      power_up_timer_cnt_r <= '0;
    else if (ana_s.por_active || generic_brownout)
      power_up_timer_cnt_r <= '0;
    else if (power_up_timer_arm_r)
      power_up_timer_cnt_r <= power_up_timer_en ? POWER_UP_TIMER_W'(POWER_UP_TIMER_CYCLES - 1) : '0;
    else if (power_up_timer_cnt_r != '0)
      power_up_timer_cnt_r <= power_up_timer_cnt_r - POWER_UP_TIMER_W'(1);
  end

  assign power_up_timer_busy = (power_up_timer_arm_r & power_up_timer_en) | (power_up_timer_cnt_r != '0);

  a_power_up_timer_count: assert property ((power_up_timer_cnt_r != '0) && !ana_s.por_active
    && !generic_brownout |=> power_up_timer_cnt_r == $past(power_up_timer_cnt_r) - POWER_UP_TIMER_W'(1))
    else $error("timer count slipped");
  a_power_up_timer_start: assert property ($fell(power_up_timer_arm_r) && power_up_timer_en && $past(power_up_timer_en) |->
    power_up_timer_cnt_r == POWER_UP_TIMER_W'(POWER_UP_TIMER_CYCLES - 1)) else $error("timer did not load");
  a_power_up_timer_hold: assert property (power_up_timer_busy |=> core_reset_hold)
    else $error("core ran while timer busy");

  //////////////////////////////////////////////////////////////////////////
  // external reset pin

  assign ext_en = cfg.low_voltage_prog_enable | cfg.ext_reset_pin_enable;
  assign ext_active_s = ext_en & !ana_s.external_reset_pin_n;

  // release delay after the pin goes high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ext_cnt_r <= '0;
    else if (ext_active_s)
      ext_cnt_r <= EXT_W'(EXT_RELEASE_CYCLES);
    else if (ext_cnt_r != '0)
      ext_cnt_r <= ext_cnt_r - EXT_W'(1);
  end

  a_ext_delay: assert property ($fell(ext_active_s) |->
    ext_cnt_r == EXT_W'(EXT_RELEASE_CYCLES)) else $error("pin release delay wrong");
  a_ext_hold: assert property (ext_active_s |=> core_reset_hold)
    else $error("core ran with reset pin low");

  //////////////////////////////////////////////////////////////////////////
  // core reset

  // power-on and the pin assert at once, without the clock
  assign arst_n = hresetn & !ana_in.por_active
    & !(ext_en & !ana_in.external_reset_pin_n);

  // release synchroniser
  always_ff @(posedge hclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rel1_r <= 1'b0;
      rel2_r <= 1'b0;
    end
    else
    begin
      rel1_r <= 1'b1;
      rel2_r <= rel1_r;
    end
  end

  // every clocked hold source
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_r <= 1'b1;
    else
      hold_r <= ana_s.por_active | generic_brownout | power_up_timer_busy | ready_wait
        | ext_active_s | (ext_cnt_r != '0) | !ana_s.osc_ready;
  end

  assign core_reset_hold = !rel2_r | hold_r;

  a_por_hold: assert property (ana_s.por_active |-> core_reset_hold)
    else $error("core ran during power-on");

  //////////////////////////////////////////////////////////////////////////
  // register bus

  assign addr_sel = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // write data phase follows the captured address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else
    begin
      wr_pend_r <= addr_sel & hwrite;
      wr_addr_r <= haddr[brs_pkg::ADDR_W-1:0];
    end
  end

  // brownout_control storage, bit 7 always writable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      soft_en_r <= brs_pkg::SOFT_EN_RST;
      bandgap_r <= brs_pkg::BANDGAP_RST;
    end
    else if (wr_pend_r && wr_addr_r == brs_pkg::BRN_CTRL_OFS)
    begin
      soft_en_r <= hwdata[brs_pkg::SOFT_EN_BIT];
      bandgap_r <= hwdata[brs_pkg::BANDGAP_BIT];
    end
  end

  // read mux, unmapped reads as zero
  always_comb
  begin
    rd_nxt = '0;
    if (haddr[brs_pkg::ADDR_W-1:0] == brs_pkg::BRN_CTRL_OFS)
    begin
      rd_nxt[brs_pkg::SOFT_EN_BIT] = soft_en_r;
      rd_nxt[brs_pkg::BANDGAP_BIT] = bandgap_r;
      rd_nxt[brs_pkg::READY_BIT] = ready_s;
    end
    else if (haddr[brs_pkg::ADDR_W-1:0] == brs_pkg::BRN_STAT_OFS)
    begin
      rd_nxt[brs_pkg::STAT_GENERIC_BIT] = generic_brownout;
      rd_nxt[brs_pkg::STAT_POWER_UP_TIMER_BIT] = power_up_timer_busy;
      rd_nxt[brs_pkg::STAT_EXT_EN_BIT] = ext_en;
      rd_nxt[brs_pkg::STAT_HOLD_BIT] = core_reset_hold;
      rd_nxt[brs_pkg::STAT_MODE_LSB +: 2] = mode;
    end
  end

  // read data taken at the address phase, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (addr_sel && !hwrite)
      hrdata <= rd_nxt;
  end

endmodule

/* File: dv/brs_ana_model.sv */
////////////////////////////////////////////////////////////////////////////////
// supply detectors, oscillator timer and reset pin as seen by the sequencer
module brs_ana_model #(
  parameter int RDY_DLY = 3
) (
  input wire logic hclk,
  input wire brs_pkg::brs_ana_out_t ana_out,
  input wire logic por_req,
  input wire logic supply_low,
  input wire logic lp_req,
  input wire logic pin_press,
  output brs_pkg::brs_ana_in_t ana_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int rdy_cnt = 0;
  // circuit becomes ready some clocks after enable, drops at the next clock once enable falls
  always @(posedge hclk)
    rdy_cnt <= !ana_out.brownout_enable ? 0 : (rdy_cnt < RDY_DLY) ? rdy_cnt + 1 : rdy_cnt;
  // detector outputs; the pin has a pull-up, so released it reads high
  always_comb
  begin
    ana_in.por_active = por_req;
    ana_in.below_threshold = supply_low;
    ana_in.circuit_ready = (rdy_cnt == RDY_DLY);
    ana_in.lp_trip = lp_req;
    ana_in.external_reset_pin_n = !pin_press;
    ana_in.osc_ready = !por_req;
  end
endmodule

/* File: dv/testbench.sv */
////////////////////////////////////////////////////////////////////////////////
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sleep_mode = 1'b0;
  logic por_req = 1'b1;
  logic supply_low = 1'b0;
  logic lp_req = 1'b0;
  logic pin_press = 1'b0;
  brs_pkg::brs_cfg_t cfg = 7'h66;
  brs_pkg::brs_ana_in_t ana_in;
  brs_pkg::brs_ana_out_t ana_out;
  logic hreadyout, hresp, generic_brownout, core_reset_hold;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int fail_count = 0;
  int checked = 0;
  // clock at 200 MHz
  always #2.5 hclk = ~hclk;
  brs_top #(.POWER_UP_TIMER_CYCLES(PW), .FILTER_CYCLES(4), .EXT_RELEASE_CYCLES(10)) brs_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfg(cfg), .ana_in(ana_in),
    .sleep_mode(sleep_mode), .ana_out(ana_out), .generic_brownout(generic_brownout),
    .core_reset_hold(core_reset_hold));
  brs_ana_model brs_ana_model_inst (.hclk(hclk), .ana_out(ana_out), .por_req(por_req),
    .supply_low(supply_low), .lp_req(lp_req), .pin_press(pin_press), .ana_in(ana_in));
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic close_out;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // compare a bus word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  // compare a single output bit
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // bounded wait for hold (sel 0), generic flag (sel 1) or bus ready (sel 2)
  task automatic wait_on(input int sel, input logic val, input int max);
    int n;
    n = 0;
    while ((sel == 0 ? core_reset_hold : sel == 1 ? generic_brownout : hreadyout) !== val)
    begin
      if (n == max)
      begin
        fail_count++;
        $display("ERROR %0t: wait timed out", $time);
        close_out();
      end
      @(posedge hclk);
      n++;
    end
  endtask
  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    wait_on(2, 1'b1, 20);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    wait_on(2, 1'b1, 20);
    rd = hrdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // power-on release, then the timer delay
  task automatic t_power_up;
    chk_bit(core_reset_hold, 1'b1);
    cyc(PW + 5);
    chk_bit(core_reset_hold, 1'b1);
    por_req <= 1'b0;
    cyc(PW);
    chk_bit(core_reset_hold, 1'b1);
    wait_on(0, 1'b0, 40);
  endtask
  // control and status register contents
  task automatic t_regs;
    bus(1'b0, 8'h00, 32'h0);
    chk_word(rd, 32'h81);
    bus(1'b1, 8'h00, 32'h40);
    bus(1'b0, 8'h00, 32'h0);
    chk_word(rd, 32'h41);
    bus(1'b1, 8'h10, 32'hff);
    bus(1'b0, 8'h10, 32'h0);
    chk_word(rd, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk_word(rd, 32'h41);
    bus(1'b0, 8'h04, 32'h0);
    chk_word(rd, 32'h34);
    chk_bit(hresp, 1'b0);
  endtask
  // every mode with sleep and the software bit; table is mode, sleep, soft, en, bandgap
  task automatic t_modes;
    logic [5:0] tbl [7];
    tbl = '{6'h3e, 6'h27, 6'h2d, 6'h17, 6'h1f, 6'h11, 6'h04};
    foreach (tbl[i])
    begin
      bus(1'b1, 8'h00, {24'h0, tbl[i][2], 7'h40});
      cfg <= brs_pkg::brs_cfg_t'({tbl[i][5:4], cfg[4:0]});
      sleep_mode <= tbl[i][3];
      cyc(10);
      chk_bit(ana_out.brownout_enable, tbl[i][1]);
      chk_bit(ana_out.bandgap_force_on, tbl[i][0]);
      bus(1'b0, 8'h00, 32'h0);
      chk_word(rd, {24'h0, tbl[i][2], 6'h20, tbl[i][1]});
    end
    bus(1'b1, 8'h00, 32'h80);
    cfg <= 7'h66;
    sleep_mode <= 1'b0;
    wait_on(0, 1'b0, 200);
  endtask
  // short dip ignored, long dip trips and restarts the timer
  task automatic t_bor;
    supply_low <= 1'b1;
    cyc(2);
    supply_low <= 1'b0;
    cyc(12);
    chk_bit(generic_brownout, 1'b0);
    supply_low <= 1'b1;
    wait_on(1, 1'b1, 20);
    cyc(1);
    chk_bit(core_reset_hold, 1'b1);
    cyc(30);
    supply_low <= 1'b0;
    wait_on(1, 1'b0, 10);
    cyc(PW - 2);
    chk_bit(core_reset_hold, 1'b1);
    wait_on(0, 1'b0, 40);
  endtask
  // low-power detector disabled, then enabled
  task automatic t_lp;
    lp_req <= 1'b1;
    cyc(8);
    chk_bit(generic_brownout, 1'b0);
    chk_bit(ana_out.low_power_brownout_enable, 1'b0);
    cfg <= 7'h6a;
    wait_on(1, 1'b1, 10);
    chk_bit(ana_out.low_power_brownout_enable, 1'b1);
    chk_bit(ana_out.brownout_level_select, 1'b1);
    cyc(1);
    chk_bit(core_reset_hold, 1'b1);
    // timer disabled: the core leaves reset without the timer delay
    lp_req <= 1'b0;
    cfg <= 7'h76;
    wait_on(0, 1'b0, 4);
    cfg <= 7'h66;
  endtask
  // reset pin under each pin-enable and programming-bit setting
  task automatic t_pin;
    for (int i = 0; i < 4; i++)
    begin
      cfg <= brs_pkg::brs_cfg_t'({cfg[6:2], i[1:0]});
      cyc(1);
      pin_press <= 1'b1;
      #1;
      chk_bit(core_reset_hold, |i[1:0]);
      cyc(8);
      chk_bit(core_reset_hold, |i[1:0]);
      pin_press <= 1'b0;
      cyc(11);
      chk_bit(core_reset_hold, |i[1:0]);
      wait_on(0, 1'b0, 12);
    end
    cfg <= 7'h66;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset, then the scenarios in turn
  initial
  begin
    cyc(8);
    hresetn <= 1'b1;
    cyc(1);
    t_power_up();
    t_regs();
    t_modes();
    t_bor();
    t_lp();
    t_pin();
    close_out();
  end
endmodule
